// ---- dv/core_timer_properties.sv ----
// port-level assertions for the core timer
`default_nettype none

module core_timer_properties (
  input wire logic                              clk,
  input wire logic                              arst_n,
  input wire logic [core_timer_pkg::ADDR_W-1:0] avs_address,
  input wire logic                              avs_read,
  input wire logic [31:0]                       avs_readdata,
  input wire logic                              avs_waitrequest,
  input wire logic                              wait_mode,
  input wire logic                              stop_exec,
  input wire logic                              stop_disabled,
  input wire logic                              irq,
  input wire logic                              wake,
  input wire logic                              chip_reset_n,
  input wire logic                              reset_pin_n_in,
  input wire logic                              reset_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic [12:0] por_cnt_ff;
  logic        por_seen_ff;

  // cycles from reset release to the first chip release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_ff  <= 13'h0000;
      por_seen_ff <= 1'b0;
    end else if (!por_seen_ff) begin
      if (chip_reset_n) begin
        por_seen_ff <= 1'b1;
      end else begin
        por_cnt_ff <= por_cnt_ff + 13'h0001;
      end
    end
  end

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence pin_pulse;
    reset_pin_oe [*3] ##1 !reset_pin_oe;
  endsequence
  sequence ctrl_read;
    avs_read && !avs_waitrequest && avs_address == 16'h0020;
  endsequence

  // ****************************************************************
  // properties
  // ****************************************************************
  // watchdog timeout drives the pin and holds the chip
  pin_low_a: assert property ($rose(reset_pin_oe) |-> pin_pulse)
    else $error("reset pin pulse length wrong");
  chip_hold_a: assert property ($rose(reset_pin_oe) |-> !chip_reset_n [*3])
    else $error("chip reset missing on timeout");
  // stop while disabled resets
  stop_reset_a: assert property (stop_exec && stop_disabled |-> ##[0:1] !chip_reset_n)
    else $error("stop did not reset");
  ext_reset_a: assert property (!reset_pin_n_in |-> ##[0:2] !chip_reset_n)
    else $error("pin low did not reset");
  clear_zero_a: assert property (ctrl_read |-> avs_readdata[3:2] == 2'h0)
    else $error("clear bits read nonzero");
  wake_irq_a: assert property ((irq && wait_mode) [*3] |-> wake)
    else $error("no wake on irq in wait");
  irq_quiet_a: assert property (!chip_reset_n [*3] |-> !irq)
    else $error("irq during chip reset");
  por_hold_a: assert property (!por_seen_ff |-> por_cnt_ff <= 13'h0fe6 && (!chip_reset_n || por_cnt_ff >= 13'h0fe0))
    else $error("power-on hold length wrong");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule : core_timer_properties

bind core_timer_rti_watchdog core_timer_properties chk (.clk, .arst_n, .avs_address,
  .avs_read, .avs_readdata, .avs_waitrequest, .wait_mode, .stop_exec, .stop_disabled,
  .irq, .wake, .chip_reset_n, .reset_pin_n_in, .reset_pin_oe);

`default_nettype wire

// ---- dv/core_timer_rti_watchdog_tb.sv ----
// self-checking testbench for the core timer
`default_nettype none

module core_timer_rti_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  localparam row_t ROWS [7] = '{'{1'b0, 16'h0020, 8'h00, 8'h03}, '{1'b1, 16'h0020, 8'h31, 8'h00},
    '{1'b0, 16'h0020, 8'h00, 8'h31}, '{1'b1, 16'h0020, 8'hcc, 8'h00},
    '{1'b0, 16'h0020, 8'h00, 8'h00}, '{1'b1, 16'h0040, 8'hff, 8'h00},
    '{1'b0, 16'h0040, 8'h00, 8'h00}};
  logic        clk, arst_n, avs_read, avs_write, wait_mode, stop_exec, stop_disabled, ext_pin_n;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, q2;
  logic        avs_waitrequest, irq, wake, chip_reset_n, pin_oe;
  logic [1:0]  mon;
  int          mismatches, cmp_count, cyc, falls, t0, n;

  assign mon = {chip_reset_n, irq};

  core_timer_rti_watchdog uut (.clk, .arst_n, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .wait_mode,
    .stop_exec, .stop_disabled, .irq, .wake, .chip_reset_n,
    .reset_pin_n_in(ext_pin_n & ~pin_oe), .reset_pin_n_out(), .reset_pin_oe(pin_oe));

  // ****************************************************************
  // clock, counters and helpers
  // ****************************************************************
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge chip_reset_n) falls++;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= ~wr;
    avs_write <= wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) chk("bus answer", 32'h0, 32'h1);
  endtask : bus

  // bounded wait for irq (0) or chip_reset_n (1)
  task automatic wait_for(input int w, input logic v, input int lim);
    int k;
    k = 0;
    while (mon[w] !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk("wait target", {31'h0, v}, {31'h0, mon[w]});
  endtask : wait_for

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // watchdog on the whole run
  initial begin
    repeat (120000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {clk, arst_n, avs_read, avs_write, wait_mode, stop_exec, stop_disabled} = '0;
    {avs_address, avs_writedata, mismatches, cmp_count, cyc, falls} = '0;
    ext_pin_n = 1'b1;
    repeat (2) @(posedge clk);
    chk("reset outputs", 32'h2, {30'h0, avs_waitrequest, chip_reset_n});
    arst_n <= 1'b1;
    t0 = cyc;
    wait_for(1, 1'b1, 5000);
    chk("hold length", 32'h1, {31'h0, (cyc - t0) inside {[4064:4072]}});
    foreach (ROWS[i]) begin
      bus(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].wr) chk("row read", {24'h0, ROWS[i].e}, q);
    end
    $display("test register rows done");
    // head counter advances one per four cycles
    bus(1'b0, 16'h0024, 8'h00);
    q2 = q;
    repeat (33) @(posedge clk);
    bus(1'b0, 16'h0024, 8'h00);
    chk("count step", 32'h9, {24'h0, q[7:0] - q2[7:0]});
    // overflow flag, irq, wake and clear
    bus(1'b1, 16'h0020, 8'h20);
    wait_for(0, 1'b1, 1200);
    wait_mode <= 1'b1;
    bus(1'b1, 16'h0020, 8'h20);
    bus(1'b0, 16'h0020, 8'h00);
    chk("overflow flag", 32'h1, {31'h0, q[7]});
    chk("wake", 32'h1, {31'h0, wake});
    bus(1'b1, 16'h0020, 8'h28);
    repeat (3) @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test overflow done");
    // periodic period for every rate code
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 16'hffc0, 8'h00);
      bus(1'b1, 16'h0020, 8'h14 | 8'(r));
      repeat (2) @(negedge clk);
      wait_for(0, 1'b1, 40000);
      t0 = cyc;
      bus(1'b1, 16'h0020, 8'h14 | 8'(r));
      repeat (2) @(negedge clk);
      wait_for(0, 1'b1, 40000);
      chk("periodic period", 32'(2048 << r), 32'(cyc - t0));
    end
    $display("test periodic done");
    // serviced watchdog stays quiet, then times out
    bus(1'b1, 16'h0020, 8'h00);
    n = falls;
    repeat (12) begin
      repeat (1500) @(posedge clk);
      bus(1'b1, 16'hffc0, 8'h00);
    end
    t0 = cyc;
    chk("serviced falls", 32'(n), 32'(falls));
    wait_for(1, 1'b0, 20000);
    chk("timeout window", 32'h1, {31'h0, (cyc - t0) inside {[14336:16400]}});
    chk("pin driven", 32'h1, {31'h0, pin_oe});
    wait_for(1, 1'b1, 5000);
    bus(1'b0, 16'h0020, 8'h00);
    chk("ctrl after timeout", 32'h03, q);
    $display("test watchdog done");
    // stop while disabled
    stop_disabled <= 1'b1;
    n = falls;
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    repeat (3) @(negedge clk);
    chk("stop reset", 32'(n + 1), 32'(falls));
    wait_for(1, 1'b1, 5000);
    // external reset pin clears the chain
    repeat (300) @(posedge clk);
    ext_pin_n <= 1'b0;
    repeat (5) @(negedge clk);
    chk("pin reset", 32'h0, {31'h0, chip_reset_n});
    @(posedge clk);
    ext_pin_n <= 1'b1;
    wait_for(1, 1'b1, 5000);
    bus(1'b0, 16'h0024, 8'h00);
    chk("count cleared", 32'h0, {27'h0, q[7:3]});
    $display("test resets done");
    complete_run();
  end
endmodule : core_timer_rti_watchdog_tb

`default_nettype wire

// ---- inc/core_timer_pkg.sv ----
// constants, types and helpers shared by the core timer design files
`default_nettype none

package core_timer_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 100_000_000; // bus clock E
  localparam int unsigned POR_CYCLES      = 4064;        // power-on hold, in E cycles
  localparam int unsigned RESET_PIN_CYC   = 3;           // least low time of reset pin
  localparam logic [11:0] POR_LAST        = 12'(POR_CYCLES - 1);
  localparam logic [1:0]  PIN_LOW_LAST    = 2'(RESET_PIN_CYC - 1);

  // ****************************************************************
  // register map: printed offsets are word indices, byte address = 4 * index
  // ****************************************************************
  localparam logic [13:0] IDX_CTRL_STATUS = 14'h0008;
  localparam logic [13:0] IDX_COUNT       = 14'h0009;
  localparam logic [13:0] IDX_WD_SERVICE  = 14'h3ff0;
  localparam int unsigned ADDR_W          = 16;

  // control/status field positions
  localparam int unsigned BIT_OVF_FLAG    = 7;
  localparam int unsigned BIT_PER_FLAG    = 6;
  localparam int unsigned BIT_OVF_EN      = 5;
  localparam int unsigned BIT_PER_EN      = 4;
  localparam int unsigned BIT_OVF_CLR     = 3;
  localparam int unsigned BIT_PER_CLR     = 2;
  localparam int unsigned BIT_RATE_LO     = 0;
  localparam int unsigned BIT_WD_SERVICE  = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h03;
  localparam logic [1:0]  RATE_RESET      = 2'h3;

  // ****************************************************************
  // divider chain layout
  // ****************************************************************
  localparam int unsigned CHAIN_W         = 15; // 2 prescale + 8 head + 5 more
  localparam int unsigned HEAD_LO         = 2;
  localparam int unsigned HEAD_HI         = 9;
  localparam int unsigned WD_W            = 3;
  localparam logic [CHAIN_W-1:0] TAP_BASE = 15'h07ff; // 2^11 period mask
  localparam logic [WD_W-1:0]    WD_LAST  = 3'h7;

  // reset sequencer states
  typedef enum logic [2:0] {
    SEQ_POR   = 3'b001,
    SEQ_RUN   = 3'b010,
    SEQ_DRIVE = 3'b100
  } seq_state_t;

  // word index hit for a byte address
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [13:0] idx);
    return (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction : addr_hit

  // next increment wraps every bit up to the selected periodic tap
  function automatic logic tap_wrap(input logic [CHAIN_W-1:0] c, input logic [1:0] sel);
    logic [CHAIN_W-1:0] m;
    m = TAP_BASE | (TAP_BASE << sel);
    return &(c | ~m);
  endfunction : tap_wrap

endpackage : core_timer_pkg

`default_nettype wire

// ---- inc/rst_ctl_if.sv ----
// carrier between the timer core and its reset sequencer
`default_nettype none

interface rst_ctl_if;
  logic hold;      // chip held in reset
  logic chain_clr; // clear the whole divider chain
  logic pin_drive; // pull the reset pin low
  logic wd_trip;   // watchdog timeout pulse
  logic stop_trip; // forbidden stop executed
  logic ext_low;   // reset pin seen low

  modport seq  (input wd_trip, stop_trip, ext_low, output hold, chain_clr, pin_drive);
  modport core (output wd_trip, stop_trip, ext_low, input hold, chain_clr, pin_drive);
endinterface : rst_ctl_if

`default_nettype wire

// ---- rtl/core_timer_rti_watchdog.sv ----
// core timer with overflow, periodic interrupt and watchdog, avalon-mm slave
//
// Behaviour
// - head counter wrap sets overflow flag
// - writing one to overflow clear clears flag
// - periodic flag set at selected tap of E/2048
// - writing one to periodic clear clears flag
// - overflow flag with enable requests interrupt
// - periodic flag with enable requests interrupt
// - clear bits are strobes, read zero
// - reset clears flags, enables; rate to ones
// - rate codes give 2^11 to 2^14 cycles
// - watchdog divides tap by eight, resets chip
// - writing zero to service bit clears watchdog
// - watchdog timeout drives reset pin low three cycles
// - any chip reset clears whole chain
// - watchdog runs in wait; forbidden stop resets
// - count register reads head counter at E/4
// - power-on hold 4064 cycles, chain cleared again
// - chain runs in wait; interrupt wakes cpu
// - included watchdog cannot be disabled
`default_nettype none

module core_timer_rti_watchdog #(
  parameter bit WATCHDOG_EN = 1'b1 // build-time watchdog option
) (
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic                              ce,
  // avalon-mm slave
  input  wire logic [core_timer_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [31:0]                       avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic [31:0]                            avs_readdata,
  output logic                                   avs_waitrequest,
  // cpu side
  input  wire logic                              wait_mode,
  input  wire logic                              stop_exec,
  input  wire logic                              stop_disabled,
  output logic                                   irq,
  output logic                                   wake,
  output logic                                   chip_reset_n,
  // reset pin, open drain
  input  wire logic                              reset_pin_n_in,
  output logic                                   reset_pin_n_out,
  output logic                                   reset_pin_oe
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  rst_ctl_if rc ();

  logic [core_timer_pkg::CHAIN_W-1:0] chain;
  logic [core_timer_pkg::WD_W-1:0]    wd_cnt_ff;
  logic                               ovf_flag_ff;
  logic                               per_flag_ff;
  logic                               ovf_en_ff;
  logic                               per_en_ff;
  logic [1:0]                         rate_ff;
  logic                               wait_ff;
  logic                               irq_ff;
  logic                               wake_ff;
  logic                               chip_rst_n_ff;
  logic                               pin_oe_ff;
  logic [31:0]                        rdata_ff;
  logic                               wreq_ff;

  logic                               req;
  logic                               acc;
  logic                               wr_acc;
  logic                               hit_ctrl;
  logic                               hit_count;
  logic                               hit_wd;
  logic                               wr_ctrl;
  logic                               ovf_evt;
  logic                               per_evt;
  logic                               wd_clear;
  logic                               wd_timeout;
  logic                               nxt_irq;
  logic [7:0]                         ctrl_rd;
  logic [31:0]                        nxt_rdata;

  // ****************************************************************
  // submodules
  // ****************************************************************
  div_chain u_chain (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .clr      (rc.chain_clr),
    .chain_ff (chain)
  );

  rst_seq u_seq (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .rc     (rc.seq)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // request is taken when waitrequest is low
  assign req       = avs_read || avs_write;
  assign acc       = req && !wreq_ff;
  assign wr_acc    = avs_write && !wreq_ff && avs_byteenable[0];
  assign hit_ctrl  = core_timer_pkg::addr_hit(avs_address, core_timer_pkg::IDX_CTRL_STATUS);
  assign hit_count = core_timer_pkg::addr_hit(avs_address, core_timer_pkg::IDX_COUNT);
  assign hit_wd    = core_timer_pkg::addr_hit(avs_address, core_timer_pkg::IDX_WD_SERVICE);
  assign wr_ctrl   = wr_acc && hit_ctrl && !rc.hold;

  // ****************************************************************
  // timer events
  // ****************************************************************
  // head counter goes from all ones to zero on the next step
  assign ovf_evt  = &chain[core_timer_pkg::HEAD_HI:0] && !rc.chain_clr;
  // selected tap of the stages after E/2048
  assign per_evt  = core_timer_pkg::tap_wrap(chain, rate_ff) && !rc.chain_clr;
  // service: a zero in bit 0 of the service word
  assign wd_clear = wr_acc && hit_wd
                    && !avs_writedata[core_timer_pkg::BIT_WD_SERVICE];
  // eighth tap event without service; no software path turns it off
  assign wd_timeout = WATCHDOG_EN && per_evt && !wd_clear && !rc.hold
                      && (wd_cnt_ff == core_timer_pkg::WD_LAST);

  // ****************************************************************
  // reset requests toward the sequencer
  // ****************************************************************
  assign rc.wd_trip   = wd_timeout;
  assign rc.stop_trip = stop_exec && stop_disabled;
  assign rc.ext_low   = !reset_pin_n_in && !pin_oe_ff;

  // ****************************************************************
  // overflow flag
  // ****************************************************************
  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_flag_ff <= 1'b0;
    end else if (ce) begin
      if (rc.hold) begin
        ovf_flag_ff <= 1'b0;
      end else if (ovf_evt) begin
        ovf_flag_ff <= 1'b1;
      end else if (wr_ctrl && avs_writedata[core_timer_pkg::BIT_OVF_CLR]) begin
        ovf_flag_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // periodic flag
  // ****************************************************************
  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_flag_ff <= 1'b0;
    end else if (ce) begin
      if (rc.hold) begin
        per_flag_ff <= 1'b0;
      end else if (per_evt) begin
        per_flag_ff <= 1'b1;
      end else if (wr_ctrl && avs_writedata[core_timer_pkg::BIT_PER_CLR]) begin
        per_flag_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // enables and rate select
  // ****************************************************************
  // writes to flag bits and clear bits store nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_en_ff <= 1'b0;
      per_en_ff <= 1'b0;
      rate_ff   <= core_timer_pkg::RATE_RESET;
    end else if (ce) begin
      if (rc.hold) begin
        ovf_en_ff <= 1'b0;
        per_en_ff <= 1'b0;
        rate_ff   <= core_timer_pkg::RATE_RESET;
      end else if (wr_ctrl) begin
        ovf_en_ff <= avs_writedata[core_timer_pkg::BIT_OVF_EN];
        per_en_ff <= avs_writedata[core_timer_pkg::BIT_PER_EN];
        rate_ff   <= avs_writedata[core_timer_pkg::BIT_RATE_LO +: 2];
      end
    end
  end

  // ****************************************************************
  // watchdog divide by eight
  // ****************************************************************
  // service clears only this stage, not the chain; keeps running in wait
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_ff <= '0;
    end else if (ce) begin
      if (rc.chain_clr || wd_clear) begin
        wd_cnt_ff <= '0;
      end else if (per_evt) begin
        wd_cnt_ff <= wd_cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************************************
  // interrupt request and wake
  // ****************************************************************
  assign nxt_irq = (ovf_flag_ff && ovf_en_ff) || (per_flag_ff && per_en_ff);

  // request stays while flag and enable both hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff  <= 1'b0;
      wake_ff <= 1'b0;
      wait_ff <= 1'b0;
    end else if (ce) begin
      irq_ff  <= nxt_irq && !rc.hold;
      wait_ff <= wait_mode && !rc.hold;
      wake_ff <= wait_ff && nxt_irq && !rc.hold;
    end
  end

  // ****************************************************************
  // chip reset and reset pin
  // ****************************************************************
  // pin is pulled low only while the sequencer drives it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chip_rst_n_ff <= 1'b0;
      pin_oe_ff     <= 1'b0;
    end else if (ce) begin
      chip_rst_n_ff <= !rc.hold;
      pin_oe_ff     <= rc.pin_drive;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // clear bits always read zero
  assign ctrl_rd = {ovf_flag_ff, per_flag_ff, ovf_en_ff, per_en_ff,
                    1'b0, 1'b0, rate_ff};

  // unmapped and service addresses read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      nxt_rdata[7:0] = ctrl_rd;
    end else if (hit_count) begin
      nxt_rdata[7:0] = chain[core_timer_pkg::HEAD_HI:core_timer_pkg::HEAD_LO];
    end
  end

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one wait state: waitrequest drops for one cycle with data ready
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wreq_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (acc) begin
        wreq_ff <= 1'b1;
      end else if (req) begin
        wreq_ff  <= 1'b0;
        rdata_ff <= avs_read ? nxt_rdata : 32'h0000_0000;
      end else begin
        wreq_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wreq_ff;
  assign irq             = irq_ff;
  assign wake            = wake_ff;
  assign chip_reset_n    = chip_rst_n_ff;
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_oe    = pin_oe_ff;

endmodule : core_timer_rti_watchdog

`default_nettype wire

// ---- rtl/div_chain.sv ----
// free-running divider chain of the core timer
`default_nettype none

module div_chain (
  input  wire logic                                clk,
  input  wire logic                                arst_n,
  input  wire logic                                ce,
  input  wire logic                                clr,
  output logic [core_timer_pkg::CHAIN_W-1:0]       chain_ff
);

  // ****************************************************************
  // counter
  // ****************************************************************
  // one step per bus clock; the low two bits form the divide-by-four
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_ff <= '0;
    end else if (ce) begin
      if (clr) begin
        chain_ff <= '0;
      end else begin
        chain_ff <= chain_ff + 1'b1;
      end
    end
  end

endmodule : div_chain

`default_nettype wire

// ---- rtl/rst_seq.sv ----
// power-on, external and watchdog reset sequencer
`default_nettype none

module rst_seq (
  input  wire logic   clk,
  input  wire logic   arst_n,
  input  wire logic   ce,
  rst_ctl_if.seq      rc
);

  core_timer_pkg::seq_state_t state_ff;
  logic [11:0]                cnt_ff;
  logic                       por_done;
  logic                       run_rst;

  assign por_done = (state_ff == core_timer_pkg::SEQ_POR) && (cnt_ff == core_timer_pkg::POR_LAST);
  assign run_rst  = (state_ff == core_timer_pkg::SEQ_RUN) && (rc.ext_low || rc.stop_trip);

  // ****************************************************************
  // state and counter
  // ****************************************************************
  // chain runs during power-on hold, then is cleared at release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= core_timer_pkg::SEQ_POR;
      cnt_ff   <= 12'h000;
    end else if (ce) begin
      case (state_ff)
        core_timer_pkg::SEQ_POR: begin
          cnt_ff <= cnt_ff + 12'h001;
          if (por_done) begin
            state_ff <= core_timer_pkg::SEQ_RUN;
            cnt_ff   <= 12'h000;
          end
        end
        core_timer_pkg::SEQ_RUN: begin
          cnt_ff <= 12'h000;
          if (rc.wd_trip) begin
            state_ff <= core_timer_pkg::SEQ_DRIVE;
          end
        end
        core_timer_pkg::SEQ_DRIVE: begin
          cnt_ff <= cnt_ff + 12'h001;
          if (cnt_ff[1:0] == core_timer_pkg::PIN_LOW_LAST) begin
            state_ff <= core_timer_pkg::SEQ_RUN;
            cnt_ff   <= 12'h000;
          end
        end
        default: begin
          state_ff <= core_timer_pkg::SEQ_POR;
          cnt_ff   <= 12'h000;
        end
      endcase
    end
  end

  // ****************************************************************
  // controls
  // ****************************************************************
  // every chip reset source clears the chain
  // timeout acts through the drive state, which keeps the core free of a loop
  assign rc.hold      = (state_ff != core_timer_pkg::SEQ_RUN) || run_rst;
  assign rc.chain_clr = por_done || run_rst
                        || (state_ff == core_timer_pkg::SEQ_DRIVE);
  assign rc.pin_drive = (state_ff == core_timer_pkg::SEQ_DRIVE);

endmodule : rst_seq

`default_nettype wire
